/* File: hdl/tone_pkg.sv */
// Purpose: Shared constants and carriers for the digit transceiver logic
// Assumes: pclk at 100 MHz, APB register access
// Notes: Times kept in their own unit; cycle counts derived from them
package tone_pkg;

	// ----------------------------------------
	// Clock and time base
	// ----------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int TICK_US = 1000; // One timing tick = 1 ms
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int TB_DIV = 28; // Time-base output divider, about 3.57 MHz

	// ----------------------------------------
	// Receiver timing, in ms ticks
	// ----------------------------------------
	localparam logic [7:0] TONE_DETECT_MS = 8'h28;  // 40 ms valid tone
	localparam logic [7:0] TONE_REJECT_MS = 8'h14;  // 20 ms rejected tone
	localparam logic [7:0] PAUSE_REDET_MS = 8'h28;  // 40 ms redetection pause
	localparam logic [7:0] PAUSE_BRIDGE_MS = 8'h14; // 20 ms bridged gap
	localparam logic [7:0] DETECT_MS = 8'h1e;       // 30 ms, inside 25..46
	localparam logic [7:0] RELEASE_MS = 8'h28;      // 40 ms, inside 35..50

	// ----------------------------------------
	// APB register map
	// ----------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	localparam logic [11:0] ADDR_TX_CODE = 12'h010;
	localparam int CTRL_OSC_SEL = 0;
	localparam int CTRL_CRYSTAL_IN = 1;
	localparam int CTRL_GEN_STOP = 2;
	localparam int IRQ_DIGIT = 0;
	localparam int IRQ_RELEASE = 1;
	localparam int IRQ_TX_START = 2;
	localparam int IRQ_W = 3;

	// ----------------------------------------
	// Digit codes
	// ----------------------------------------
	localparam logic [3:0] CODE_D = 4'h0;
	localparam logic [3:0] CODE_0 = 4'ha;
	localparam logic [3:0] CODE_STAR = 4'hb;
	localparam logic [3:0] CODE_HASH = 4'hc;
	localparam logic [3:0] CODE_A = 4'hd;
	localparam logic [3:0] CODE_B = 4'he;
	localparam logic [3:0] CODE_C = 4'hf;

	// Receiver post-processor states
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_QUAL = 2'b01,
		RX_HELD = 2'b10,
		RX_GAP = 2'b11
	} rx_state_t;

	// Detected tone pair from the filter bank
	typedef struct packed {
		logic present;
		logic [1:0] row;
		logic [1:0] col;
	} tone_pair_t;

	// Generator output
	typedef struct packed {
		logic active;
		logic [3:0] code;
	} gen_out_t;

endpackage

/* File: hdl/ms_ticker.sv */
// Purpose: Millisecond tick and shared time-base divider
// Assumes: Selected time base drives the divider
// Notes: Tick is one pclk wide
`timescale 1ns/100ps
`default_nettype none
module ms_ticker #(
	parameter int TICK_CYCLES = tone_pkg::TICK_CYC,
	parameter int TB_DIVIDE = tone_pkg::TB_DIV
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Time base control
	input wire logic run,
	// Outputs
	output logic tick,
	output logic timebase
);
	// Elaboration check of the divider values
	if (TICK_CYCLES < 2 || TB_DIVIDE < 2) begin : g_bad_div
		$error("ms_ticker: divider values too small");
	end

	typedef struct packed {
		logic [31:0] cnt;
		logic [7:0] tb;
		logic tick;
		logic clk;
	} tick_state_t;

	tick_state_t s_r;
	tick_state_t s_nxt;

	// Divide the time base into ms ticks and the shared clock
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (run) begin
			if (s_r.cnt == 32'(TICK_CYCLES - 1)) begin
				s_nxt.cnt = '0;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 32'h1;
			end
			if (s_r.tb == 8'(TB_DIVIDE / 2 - 1)) begin
				s_nxt.tb = '0;
				s_nxt.clk = ~s_r.clk;
			end else begin
				s_nxt.tb = s_r.tb + 8'h1;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
	assign timebase = s_r.clk;
endmodule // ms_ticker
`default_nettype wire

/* File: hdl/tone_digit_xcvr.sv */
// Purpose: Digital side of a dual-tone digit transceiver
// Assumes: Tone pair detection from the analog filter bank arrives synchronous
// Notes: APB slave holds control, status, interrupt and generator registers
//
// Overview of operation
// - A tone pair lasting 40 ms or more is reported as a digit.
// - A tone pair of 20 ms or less is never reported.
// - After a gap of 40 ms or more the next pair is a new digit.
// - Gaps of 20 ms or less are bridged; digit stays asserted.
// - Result asserted 25-46 ms after onset, released 35-50 ms after end.
// - Code outputs drive while output enable low, float while high.
// - Codes: 1-9 binary, 0=1010, star=1011, hash=1100, A=1101, B=1110.
// - C is 1111, D is 0000; generator uses the same codes.
// - Valid flag and code rise on detection, clear after timed pause.
// - Strobe falling edge captures generator code and starts the tone.
// - Stop high disables the tone until a new code is captured.
// - Oscillator select high runs from the own crystal oscillator.
// - Time base is driven out; with crystal_in high, select low, shared line used.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module tone_digit_xcvr #(
	parameter int TICK_CYCLES = tone_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Tone detector input
	input wire tone_pkg::tone_pair_t tone_in,
	// Receiver code pins
	input wire logic receiver_output_enable_n,
	output logic [3:0] rx_code_out,
	output logic [3:0] rx_code_oe,
	output logic digit_valid_flag,
	// Generator pins
	input wire logic [3:0] tx_code_inputs,
	input wire logic tone_code_strobe,
	input wire logic generator_stop,
	output tone_pkg::gen_out_t gen_out,
	// Time base
	input wire logic crystal_in,
	input wire logic oscillator_select,
	input wire logic shared_timebase_in,
	output logic shared_timebase_out,
	output logic crystal_out,
	// Interrupt
	output logic irq
);
	// Elaboration check of the tick divider
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("tone_digit_xcvr: TICK_CYCLES too small");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		tone_pkg::rx_state_t st;
		logic [7:0] on_ms;
		logic [7:0] off_ms;
		logic [3:0] code;
		logic [3:0] cand;
		logic valid;
		logic strobe_d;
		logic [3:0] tx_code;
		logic tx_active;
		logic [2:0] ctrl;
		logic [tone_pkg::IRQ_W-1:0] irq_stat;
		logic [tone_pkg::IRQ_W-1:0] irq_mask;
		logic [31:0] rdata;
		logic tb_d;
	} xcvr_state_t;

	xcvr_state_t s_r;
	xcvr_state_t s_nxt;
	logic tick;
	logic tb_clk;
	logic run;
	logic osc_own;
	logic osc_ext;
	logic wr_stb;
	logic rd_stb;
	logic [3:0] pair_code;
	logic strobe_fall;
	logic stop_any;
	logic [tone_pkg::IRQ_W-1:0] ev;

	// Time base source selection
	assign osc_own = oscillator_select & s_r.ctrl[tone_pkg::CTRL_OSC_SEL];
	assign osc_ext = crystal_in & ~oscillator_select;
	assign run = osc_own | (osc_ext & (shared_timebase_in ^ s_r.tb_d));

	// Tick divider from the time base
	ms_ticker #(
		.TICK_CYCLES(TICK_CYCLES),
		.TB_DIVIDE(tone_pkg::TB_DIV)
	) u_ticker (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.tick(tick),
		.timebase(tb_clk)
	);

	// Shared time-base output and crystal drive
	assign shared_timebase_out = osc_own ? tb_clk : 1'b0;
	assign crystal_out = osc_own ? ~tb_clk : 1'b0;

	// Row/column to code mapping
	always_comb begin
		pair_code = tone_pkg::CODE_D;
		case ({tone_in.row, tone_in.col})
			4'h0: pair_code = 4'h1;
			4'h1: pair_code = 4'h2;
			4'h2: pair_code = 4'h3;
			4'h3: pair_code = tone_pkg::CODE_A;
			4'h4: pair_code = 4'h4;
			4'h5: pair_code = 4'h5;
			4'h6: pair_code = 4'h6;
			4'h7: pair_code = tone_pkg::CODE_B;
			4'h8: pair_code = 4'h7;
			4'h9: pair_code = 4'h8;
			4'ha: pair_code = 4'h9;
			4'hb: pair_code = tone_pkg::CODE_C;
			4'hc: pair_code = tone_pkg::CODE_STAR;
			4'hd: pair_code = tone_pkg::CODE_0;
			4'he: pair_code = tone_pkg::CODE_HASH;
			4'hf: pair_code = tone_pkg::CODE_D;
			default: pair_code = tone_pkg::CODE_D;
		endcase
	end

	// APB strobes, code strobe falling edge and combined stop
	assign wr_stb = psel & penable & pwrite;
	assign rd_stb = psel & ~penable & ~pwrite;
	assign strobe_fall = s_r.strobe_d & ~tone_code_strobe;
	assign stop_any = generator_stop | s_r.ctrl[tone_pkg::CTRL_GEN_STOP];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		ev = '0;
		s_nxt.strobe_d = tone_code_strobe;
		s_nxt.tb_d = shared_timebase_in;

		// Receiver post-processor, counted in ms ticks
		case (s_r.st)
			tone_pkg::RX_IDLE: begin
				s_nxt.on_ms = '0;
				if (tone_in.present) begin
					s_nxt.st = tone_pkg::RX_QUAL;
					s_nxt.cand = pair_code;
				end
			end
			tone_pkg::RX_QUAL: begin
				if (!tone_in.present || pair_code != s_r.cand) begin
					s_nxt.st = tone_pkg::RX_IDLE;
				end else if (tick) begin
					s_nxt.on_ms = s_r.on_ms + 8'h1;
					if (s_r.on_ms + 8'h1 >= tone_pkg::DETECT_MS) begin
						s_nxt.st = tone_pkg::RX_HELD;
						s_nxt.valid = 1'b1;
						s_nxt.code = s_r.cand;
						ev[tone_pkg::IRQ_DIGIT] = 1'b1;
					end
				end
			end
			tone_pkg::RX_HELD: begin
				s_nxt.off_ms = '0;
				if (!tone_in.present) begin
					s_nxt.st = tone_pkg::RX_GAP;
				end
			end
			tone_pkg::RX_GAP: begin
				if (tone_in.present && s_r.off_ms <= tone_pkg::PAUSE_BRIDGE_MS) begin
					s_nxt.st = tone_pkg::RX_HELD;
				end else if (tick) begin
					s_nxt.off_ms = s_r.off_ms + 8'h1;
					if (s_r.off_ms + 8'h1 >= tone_pkg::RELEASE_MS) begin
						s_nxt.st = tone_pkg::RX_IDLE;
						s_nxt.valid = 1'b0;
						s_nxt.code = '0;
						ev[tone_pkg::IRQ_RELEASE] = 1'b1;
					end
				end
			end
			default: s_nxt.st = tone_pkg::RX_IDLE;
		endcase

		// Generator: stop clears, then strobe falling edge restarts, so strobe wins
		if (stop_any) begin
			s_nxt.tx_active = 1'b0;
		end
		if (strobe_fall) begin
			s_nxt.tx_code = tx_code_inputs;
			s_nxt.tx_active = 1'b1;
			ev[tone_pkg::IRQ_TX_START] = 1'b1;
		end

		// APB writes
		if (wr_stb) begin
			case (paddr)
				tone_pkg::ADDR_CTRL: s_nxt.ctrl = pwdata[2:0];
				tone_pkg::ADDR_IRQ_MASK: s_nxt.irq_mask = pwdata[tone_pkg::IRQ_W-1:0];
				tone_pkg::ADDR_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~pwdata[tone_pkg::IRQ_W-1:0];
				tone_pkg::ADDR_TX_CODE: begin
					s_nxt.tx_code = pwdata[3:0];
					s_nxt.tx_active = 1'b1;
				end
				default: s_nxt.ctrl = s_r.ctrl;
			endcase
		end
		// Events set after clear so set wins
		s_nxt.irq_stat = s_nxt.irq_stat | ev;

		// APB read data captured in setup
		if (rd_stb) begin
			case (paddr)
				tone_pkg::ADDR_CTRL: s_nxt.rdata = {29'h0, s_r.ctrl};
				tone_pkg::ADDR_STATUS: s_nxt.rdata = {22'h0, s_r.tx_active, s_r.tx_code, s_r.valid, s_r.code};
				tone_pkg::ADDR_IRQ_STAT: s_nxt.rdata = {29'h0, s_r.irq_stat};
				tone_pkg::ADDR_IRQ_MASK: s_nxt.rdata = {29'h0, s_r.irq_mask};
				tone_pkg::ADDR_TX_CODE: s_nxt.rdata = {28'h0, s_r.tx_code};
				default: s_nxt.rdata = 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{st: tone_pkg::RX_IDLE, ctrl: 3'h1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// APB answers in the access cycle, no wait states
	assign pready = 1'b1;
	assign pslverr = psel & penable & (paddr[11:0] > tone_pkg::ADDR_TX_CODE || paddr[1:0] != 2'b00);
	assign prdata = s_r.rdata;

	// Three-state code pins
	assign rx_code_out = s_r.code;
	assign rx_code_oe = {4{~receiver_output_enable_n}};
	assign digit_valid_flag = s_r.valid;

	assign gen_out = '{active: s_r.tx_active & ~stop_any, code: s_r.tx_code};

	// A set mask bit hides its event from the interrupt line
	assign irq = |(s_r.irq_stat & ~s_r.irq_mask);
endmodule // tone_digit_xcvr
`default_nettype wire

/* File: tb/tone_digit_xcvr_props.sv */
// Purpose: Port checker for the digit transceiver
// Assumes: Own oscillator stays enabled in control
// Notes: Times counted in ticks of TICK_CYCLES
`timescale 1ns/100ps
`default_nettype none
module tone_digit_xcvr_props #(
	parameter int TICK_CYCLES = 20
) (
	// Clock, reset, bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	// Receiver
	input wire tone_pkg::tone_pair_t tone_in,
	input wire logic receiver_output_enable_n,
	input wire logic [3:0] rx_code_out,
	input wire logic [3:0] rx_code_oe,
	input wire logic digit_valid_flag,
	input wire logic oscillator_select,
	// Generator
	input wire logic [3:0] tx_code_inputs,
	input wire logic tone_code_strobe,
	input wire logic generator_stop,
	input wire tone_pkg::gen_out_t gen_out
);
	localparam int T = TICK_CYCLES;
	localparam logic [63:0] TAB = 64'h0cabf987e654d321;
	int pres_cnt, abs_cnt, since;
	logic [3:0] key_r, cap_r;
	logic str_d, start;
	// Tone start by strobe or bus write
	assign start = (str_d & ~tone_code_strobe) | (psel & penable & pwrite & (paddr == tone_pkg::ADDR_TX_CODE));
	// Run lengths and latched code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pres_cnt <= 0;
			abs_cnt <= 0;
			since <= 99;
			key_r <= 4'h0;
			cap_r <= 4'h0;
			str_d <= 1'b0;
		end else begin
			key_r <= {tone_in.row, tone_in.col};
			pres_cnt <= !tone_in.present ? 0 : ({tone_in.row, tone_in.col} != key_r) ? 1 : pres_cnt + 1;
			abs_cnt <= tone_in.present ? 0 : abs_cnt + 1;
			str_d <= tone_code_strobe;
			since <= start ? 0 : since + 1;
			if (str_d && !tone_code_strobe) cap_r <= tx_code_inputs;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_latch; $fell(tone_code_strobe) && !generator_stop; endsequence
	sequence s_tone; ##[1:3] (gen_out.active && gen_out.code == cap_r); endsequence
	AST_OE: assert property (rx_code_oe == {4{~receiver_output_enable_n}})
		else $error("code enables wrong");
	AST_NO_SHORT: assert property ($rose(digit_valid_flag) |-> pres_cnt > 21 * T)
		else $error("digit on short tone");
	AST_DETECT_BY: assert property (oscillator_select && pres_cnt == 47 * T |-> digit_valid_flag)
		else $error("digit not reported");
	AST_CODE: assert property ($rose(digit_valid_flag) |-> rx_code_out == TAB[{tone_in.row, tone_in.col} * 4 +: 4])
		else $error("wrong digit code");
	AST_CLEAR: assert property (!digit_valid_flag |-> rx_code_out == 4'h0)
		else $error("code not cleared");
	AST_BRIDGE: assert property ($fell(digit_valid_flag) |-> abs_cnt > 34 * T)
		else $error("early release");
	AST_RELEASE_BY: assert property (oscillator_select && abs_cnt == 51 * T |-> !digit_valid_flag)
		else $error("late release");
	AST_GEN_START: assert property (s_latch |-> s_tone)
		else $error("tone not started");
	AST_GEN_STOP: assert property (generator_stop |-> !gen_out.active)
		else $error("tone during stop");
	AST_NO_RESUME: assert property ($rose(gen_out.active) |-> since < 4)
		else $error("tone resumed");
endmodule // tone_digit_xcvr_props
bind tone_digit_xcvr tone_digit_xcvr_props #(.TICK_CYCLES(TICK_CYCLES)) props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.tone_in(tone_in), .receiver_output_enable_n(receiver_output_enable_n),
	.rx_code_out(rx_code_out), .rx_code_oe(rx_code_oe), .digit_valid_flag(digit_valid_flag),
	.oscillator_select(oscillator_select), .tx_code_inputs(tx_code_inputs),
	.tone_code_strobe(tone_code_strobe), .generator_stop(generator_stop), .gen_out(gen_out)
);
`default_nettype wire

/* File: tb/host_dialer.sv */
// Purpose: Host model driving the generator pins
// Assumes: Device samples pins on pclk
// Notes: Widths and data windows held W cycles
`timescale 1ns/100ps
`default_nettype none
module host_dialer #(
	parameter int W = 45
) (
	// Clock
	input wire logic pclk,
	// Generator pins
	output logic [3:0] tx_code_inputs,
	output logic tone_code_strobe,
	output logic generator_stop
);
	// Idle levels
	initial begin
		tx_code_inputs = 4'h0;
		tone_code_strobe = 1'b1;
		generator_stop = 1'b0;
	end
	// Latch a code, stop optionally tied to strobe
	task automatic dial(input logic [3:0] c, input logic tied);
		@(posedge pclk);
		tx_code_inputs <= c;
		generator_stop <= tied;
		repeat (W) @(posedge pclk);
		tone_code_strobe <= 1'b0;
		generator_stop <= 1'b0;
		repeat (W) @(posedge pclk);
		tx_code_inputs <= ~c;
		tone_code_strobe <= ~tied;
	endtask
	// Stop level held a full pulse width
	task automatic stop(input logic v);
		@(posedge pclk);
		generator_stop <= v;
		repeat (W) @(posedge pclk);
	endtask
endmodule // host_dialer
`default_nettype wire

/* File: tb/test_dual_tone_digit_transceiver_logic.sv */
// Purpose: Self-checking bench of the transceiver
// Assumes: Short tick, own oscillator until clk_test selects the shared time-base line
// Notes: Expected codes from a key table
`timescale 1ns/100ps
`default_nettype none
module test_dual_tone_digit_transceiver_logic;
	localparam int T = 20;
	localparam logic [63:0] TAB = 64'h0cabf987e654d321;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	tone_pkg::tone_pair_t tone_in;
	logic receiver_output_enable_n, digit_valid_flag, tone_code_strobe, generator_stop;
	logic [3:0] rx_code_out, rx_code_oe, tx_code_inputs;
	tone_pkg::gen_out_t gen_out;
	logic crystal_in, oscillator_select, shared_timebase_in, shared_timebase_out, crystal_out, irq;
	int miscompares, comparisons;
	tone_digit_xcvr #(.TICK_CYCLES(T)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tone_in(tone_in), .receiver_output_enable_n(receiver_output_enable_n),
		.rx_code_out(rx_code_out), .rx_code_oe(rx_code_oe), .digit_valid_flag(digit_valid_flag),
		.tx_code_inputs(tx_code_inputs), .tone_code_strobe(tone_code_strobe),
		.generator_stop(generator_stop), .gen_out(gen_out), .crystal_in(crystal_in),
		.oscillator_select(oscillator_select), .shared_timebase_in(shared_timebase_in),
		.shared_timebase_out(shared_timebase_out), .crystal_out(crystal_out), .irq(irq)
	);
	host_dialer host (
		.pclk(pclk), .tx_code_inputs(tx_code_inputs), .tone_code_strobe(tone_code_strobe),
		.generator_stop(generator_stop)
	);
	// Shared time-base line from a neighbouring device
	always @(posedge pclk) begin
		if (crystal_in) begin
			shared_timebase_in <= ~shared_timebase_in;
		end
	end
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Bus transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk(pslverr, a > 12'h010);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic regs_test();
		apb(1'b0, tone_pkg::ADDR_CTRL, 0);
		chk(rd, 1);
		apb(1'b0, tone_pkg::ADDR_STATUS, 0);
		chk(rd, 0);
		apb(1'b1, 12'h020, 32'hffff);
		apb(1'b0, 12'h020, 0);
		chk(rd, 0);
		@(posedge pclk);
		receiver_output_enable_n <= 1'b1;
		@(negedge pclk);
		chk(rx_code_oe, 4'h0);
		@(posedge pclk);
		receiver_output_enable_n <= 1'b0;
		@(negedge pclk);
		chk(rx_code_oe, 4'hf);
	endtask
	// One digit, detect and release timed
	task automatic key(input logic [3:0] k);
		int n;
		@(posedge pclk);
		tone_in <= {1'b1, k};
		n = 0;
		while (digit_valid_flag !== 1'b1 && n < 60 * T) begin
			@(negedge pclk);
			n++;
		end
		chk(n >= 25 * T && n <= 46 * T, 1);
		chk(rx_code_out, TAB[k * 4 +: 4]);
		repeat (50 * T - n) @(posedge pclk);
		tone_in <= {1'b0, ~k};
		n = 0;
		while (digit_valid_flag !== 1'b0 && n < 60 * T) begin
			@(negedge pclk);
			n++;
		end
		chk(n >= 35 * T && n <= 50 * T, 1);
		chk(rx_code_out, 4'h0);
		repeat (10 * T) @(posedge pclk);
	endtask
	task automatic irq_test();
		apb(1'b0, tone_pkg::ADDR_IRQ_STAT, 0);
		chk(rd[2:0], 3'h3);
		@(negedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, tone_pkg::ADDR_IRQ_MASK, 32'h7);
		@(negedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, tone_pkg::ADDR_IRQ_STAT, 32'h7);
		apb(1'b1, tone_pkg::ADDR_IRQ_MASK, 0);
		apb(1'b0, tone_pkg::ADDR_IRQ_STAT, 0);
		chk(rd, 0);
		@(negedge pclk);
		chk(irq, 1'b0);
	endtask
	// Short tone, then bridged gap
	task automatic tone_test();
		@(posedge pclk);
		tone_in <= {1'b1, 4'h5};
		repeat (20 * T) @(posedge pclk);
		tone_in <= {1'b0, 4'ha};
		repeat (20 * T) @(negedge pclk);
		chk(digit_valid_flag, 1'b0);
		@(posedge pclk);
		tone_in <= {1'b1, 4'h9};
		repeat (35 * T) @(posedge pclk);
		tone_in <= {1'b0, 4'h6};
		repeat (18 * T) @(negedge pclk);
		chk({digit_valid_flag, rx_code_out}, 5'h18);
		@(posedge pclk);
		tone_in <= {1'b1, 4'h9};
		repeat (10 * T) @(posedge pclk);
		tone_in <= {1'b0, 4'h6};
		repeat (60 * T) @(negedge pclk);
		chk(digit_valid_flag, 1'b0);
	endtask
	task automatic gen_test();
		host.dial(4'h5, 1'b0);
		chk(gen_out, 5'h15);
		host.stop(1'b1);
		chk(gen_out.active, 1'b0);
		host.stop(1'b0);
		chk(gen_out.active, 1'b0);
		host.dial(tone_pkg::CODE_C, 1'b1);
		chk(gen_out, 5'h1f);
		apb(1'b1, tone_pkg::ADDR_TX_CODE, 32'h3);
		apb(1'b0, tone_pkg::ADDR_STATUS, 0);
		chk(rd[9:5], 5'h13);
		apb(1'b0, tone_pkg::ADDR_IRQ_STAT, 0);
		chk(rd[2:0], 3'h7);
		apb(1'b1, tone_pkg::ADDR_CTRL, 32'h5);
		@(negedge pclk);
		chk(gen_out.active, 1'b0);
		apb(1'b1, tone_pkg::ADDR_CTRL, 32'h1);
		@(negedge pclk);
		chk(gen_out.active, 1'b0);
	endtask
	task automatic clk_test();
		int n;
		logic v;
		@(negedge pclk);
		v = shared_timebase_out;
		n = 0;
		while (shared_timebase_out === v && n < 100) begin
			@(negedge pclk);
			n++;
		end
		chk(n < 100, 1);
		@(posedge pclk);
		oscillator_select <= 1'b0;
		crystal_in <= 1'b1;
		repeat (5) @(negedge pclk);
		chk(shared_timebase_out, 1'b0);
		chk(crystal_out, 1'b0);
		key(4'h2);
	endtask
	// Watchdog, about twice the expected run
	initial begin
		#800000;
		miscompares++;
		complete_run();
	end
	// Main sequence
	initial begin
		miscompares = 0;
		comparisons = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		tone_in = '0;
		receiver_output_enable_n = 1'b0;
		crystal_in = 1'b0;
		oscillator_select = 1'b1;
		shared_timebase_in = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		regs_test();
		key(4'h0);
		irq_test();
		for (int k = 0; k < 16; k++) key(k[3:0]);
		tone_test();
		gen_test();
		clk_test();
		complete_run();
	end
endmodule // test_dual_tone_digit_transceiver_logic
`default_nettype wire
